/* File: logic/core_return_nop_decode.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - Idle opcode: one cycle, changes only the program counter (advanced in Q4)
// - Idle decodes in Q1, then does nothing
// - Interrupt return: enable in Q3, pop Q4
// - Legacy load copies W into config
// - Config register also reachable as file register
// - Legacy load kept for older code
module core_return_nop_decode #(
  parameter int DATA_W = ret_nop_pkg::DATA_W,
  parameter int PC_W = ret_nop_pkg::PC_W
) (
  clk_sys,
  srst,
  insn,
  insn_valid,
  stack_top,
  file_wr,
  file_wdata,
  cfg_sel,
  file_w_wr,
  w_q,
  cfg_q,
  pc_q,
  global_irq_enable_q,
  pop_q,
  phase_q,
  second_cycle_q,
  fetch_q
);
  input wire logic clk_sys;                          // Core clock
  input wire logic srst;                             // Synchronous reset
  input wire logic [ret_nop_pkg::INSN_W-1:0] insn;   // Instruction held for the cycle
  input wire logic insn_valid;                       // Instruction present at Q1
  input wire logic [PC_W-1:0] stack_top;             // Return stack top
  input wire logic file_wr;                          // File write strobe in Q4
  input wire logic [DATA_W-1:0] file_wdata;          // File write data
  input wire logic cfg_sel;                          // File address hits config
  input wire logic file_w_wr;                        // Other instruction writes W in Q4
  output logic [DATA_W-1:0] w_q;                     // Working register
  output logic [DATA_W-1:0] cfg_q;                   // Timer/prescaler config
  output logic [PC_W-1:0] pc_q;                      // Program counter
  output logic global_irq_enable_q;                  // Interrupt enable bit
  output logic pop_q;                                // Stack pop pulse
  output ret_nop_pkg::phase_t phase_q;               // Current phase
  output logic second_cycle_q;                       // Idle second cycle
  output logic fetch_q;                              // Request next instruction

  // ****************************************
  // Decode
  // ****************************************
  decode_if dbus ();
  op_decoder u_dec (.insn(insn), .dec(dbus.dec));

  ret_nop_pkg::op_t op_q;                // Latched operation
  logic [DATA_W-1:0] lit_q;              // Literal read in Q2
  logic active;                          // Executing a first cycle

  assign active = !second_cycle_q;

  // Phase counter, Q1 to Q4
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_q <= ret_nop_pkg::Q1;
    end else begin
      unique case (phase_q)
        ret_nop_pkg::Q1: phase_q <= ret_nop_pkg::Q2;
        ret_nop_pkg::Q2: phase_q <= ret_nop_pkg::Q3;
        ret_nop_pkg::Q3: phase_q <= ret_nop_pkg::Q4;
        ret_nop_pkg::Q4: phase_q <= ret_nop_pkg::Q1;
      endcase
    end
  end

  // Latch decoded op in Q1 only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_q <= ret_nop_pkg::OP_OTHER;
    end else if (phase_q == ret_nop_pkg::Q1) begin
      if (active && insn_valid) begin
        op_q <= dbus.op;
      end else begin
        op_q <= ret_nop_pkg::OP_OTHER;
      end
    end
  end

  // Literal read in Q2
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lit_q <= ret_nop_pkg::W_RESET;
    end else if (phase_q == ret_nop_pkg::Q2 && op_q == ret_nop_pkg::OP_LIT_RET) begin
      lit_q <= dbus.literal;
    end
  end

  // ****************************************
  // Execute
  // ****************************************
  // Interrupt enable set in Q3 of interrupt return
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      global_irq_enable_q <= 1'b0;
    end else if (phase_q == ret_nop_pkg::Q3 && op_q == ret_nop_pkg::OP_IRQ_RET) begin
      global_irq_enable_q <= 1'b1;
    end
  end

  // Stack pop and program counter load in Q4
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_q <= ret_nop_pkg::PC_RESET;
      pop_q <= 1'b0;
    end else if (phase_q == ret_nop_pkg::Q4 && (op_q == ret_nop_pkg::OP_IRQ_RET ||
                 op_q == ret_nop_pkg::OP_LIT_RET)) begin
      pc_q <= stack_top;
      pop_q <= 1'b1;
    end else begin
      pop_q <= 1'b0;
      if (phase_q == ret_nop_pkg::Q4 && !second_cycle_q) begin
        pc_q <= pc_q + PC_W'(1);  // Sequential advance
      end
    end
  end

  // Working register: literal return writes in Q4
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      w_q <= ret_nop_pkg::W_RESET;
    end else if (phase_q == ret_nop_pkg::Q4 && op_q == ret_nop_pkg::OP_LIT_RET) begin
      w_q <= lit_q;
    end else if (phase_q == ret_nop_pkg::Q4 && file_w_wr && op_q == ret_nop_pkg::OP_OTHER
                 && active) begin
      w_q <= file_wdata;
    end
  end

  // Config register: legacy load or file write, no flags touched
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_q <= ret_nop_pkg::CFG_RESET;
    end else if (phase_q == ret_nop_pkg::Q4 && op_q == ret_nop_pkg::OP_CFG_LOAD) begin
      cfg_q <= w_q;
    end else if (phase_q == ret_nop_pkg::Q4 && file_wr && cfg_sel &&
                 op_q == ret_nop_pkg::OP_OTHER && active) begin
      cfg_q <= file_wdata;
    end
  end

  // Second cycle of two-cycle returns is idle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      second_cycle_q <= 1'b0;
    end else if (phase_q == ret_nop_pkg::Q4) begin
      second_cycle_q <= active && (op_q == ret_nop_pkg::OP_IRQ_RET ||
                                   op_q == ret_nop_pkg::OP_LIT_RET);
    end
  end

  // Fetch request pulses in Q4 of every cycle, including the idle second cycle of a return
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= (phase_q == ret_nop_pkg::Q3);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence irq_ret_q1_s;
    phase_q == ret_nop_pkg::Q1 && active && insn_valid &&
    dbus.op == ret_nop_pkg::OP_IRQ_RET;
  endsequence

  sequence lit_ret_q1_s;
    phase_q == ret_nop_pkg::Q1 && active && insn_valid &&
    dbus.op == ret_nop_pkg::OP_LIT_RET;
  endsequence

  irq_enable_set_a: assert property (@(posedge clk_sys) disable iff (srst)
    irq_ret_q1_s |-> ##3 global_irq_enable_q)
    else $error("interrupt enable not set in Q3");

  irq_pop_a: assert property (@(posedge clk_sys) disable iff (srst)
    irq_ret_q1_s |-> ##4 (pop_q && pc_q == $past(stack_top)))
    else $error("interrupt return did not pop");

  irq_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    irq_ret_q1_s |-> ##4 second_cycle_q [*4])
    else $error("interrupt return second cycle missing");

  lit_w_a: assert property (@(posedge clk_sys) disable iff (srst)
    lit_ret_q1_s |-> ##4
    (w_q == $past(insn[ret_nop_pkg::LIT_LSB +: DATA_W], 4) && pop_q))
    else $error("literal return did not load W");

  idle_nochg_a: assert property (@(posedge clk_sys) disable iff (srst)
    (phase_q == ret_nop_pkg::Q1 && active && insn_valid &&
     dbus.op == ret_nop_pkg::OP_IDLE) |-> ##4
    ($stable(w_q) && $stable(cfg_q) && $stable(global_irq_enable_q) && !second_cycle_q))
    else $error("idle instruction changed state");

  cfg_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    (phase_q == ret_nop_pkg::Q4 && op_q == ret_nop_pkg::OP_CFG_LOAD) |=>
    (cfg_q == $past(w_q) && !second_cycle_q))
    else $error("legacy load did not copy W");

  cfg_file_a: assert property (@(posedge clk_sys) disable iff (srst)
    (phase_q == ret_nop_pkg::Q4 && op_q == ret_nop_pkg::OP_OTHER && active &&
     file_wr && cfg_sel) |=> cfg_q == $past(file_wdata))
    else $error("config file write lost");

  pop_phase_a: assert property (@(posedge clk_sys) disable iff (srst)
    pop_q |-> $past(phase_q) == ret_nop_pkg::Q4)
    else $error("pop outside Q4");
endmodule : core_return_nop_decode

/* File: pkg/ret_nop_pkg.sv */
package ret_nop_pkg;
  // ****************************************
  // Instruction word layout
  // ****************************************
  localparam int INSN_W = 14;  // Core instruction width
  localparam int DATA_W = 8;   // Working register width
  localparam int PC_W = 13;    // Program counter width
  // Idle opcode: bits 13:7 and 4:0 zero, bits 6:5 are don't care
  localparam logic [13:0] IDLE_MASK = 14'h3f9f;
  localparam logic [13:0] IDLE_CODE = 14'h0000;
  // Interrupt return opcode
  localparam logic [13:0] IRQ_RET_CODE = 14'h0009;
  // Legacy configuration load opcode
  localparam logic [13:0] CFG_LOAD_CODE = 14'h0062;
  // Literal return: 11 01xx kkkk kkkk
  localparam logic [13:0] LIT_RET_MASK = 14'h3c00;
  localparam logic [13:0] LIT_RET_CODE = 14'h3400;
  // Field positions
  localparam int LIT_LSB = 0;
  // ****************************************
  // Phases and operations
  // ****************************************
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;
  typedef enum logic [2:0] {OP_OTHER, OP_IDLE, OP_IRQ_RET, OP_CFG_LOAD, OP_LIT_RET} op_t;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;     // Working register after reset
  localparam logic [DATA_W-1:0] CFG_RESET = 8'hff;   // Config register after reset
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;   // Program counter after reset
endpackage : ret_nop_pkg

/* File: pkg/decode_if.sv */
`timescale 1ns/1ns
// ****************************************
// Decoder to core carrier
// ****************************************
interface decode_if;
  ret_nop_pkg::op_t op;                              // Decoded operation
  logic [ret_nop_pkg::DATA_W-1:0] literal;           // Literal field
  modport dec (output op, output literal);
  modport core (input op, input literal);
endinterface : decode_if

/* File: logic/op_decoder.sv */
`timescale 1ns/1ns
// ****************************************
// Opcode classifier
// ****************************************
module op_decoder (
  input wire logic [ret_nop_pkg::INSN_W-1:0] insn,
  decode_if.dec dec
);
  // Match opcode patterns
  always_comb begin
    dec.literal = insn[ret_nop_pkg::LIT_LSB +: ret_nop_pkg::DATA_W];
    if ((insn & ret_nop_pkg::IDLE_MASK) == ret_nop_pkg::IDLE_CODE) begin
      dec.op = ret_nop_pkg::OP_IDLE;
    end else if (insn == ret_nop_pkg::IRQ_RET_CODE) begin
      dec.op = ret_nop_pkg::OP_IRQ_RET;
    end else if (insn == ret_nop_pkg::CFG_LOAD_CODE) begin
      dec.op = ret_nop_pkg::OP_CFG_LOAD;
    end else if ((insn & ret_nop_pkg::LIT_RET_MASK) == ret_nop_pkg::LIT_RET_CODE) begin
      dec.op = ret_nop_pkg::OP_LIT_RET;
    end else begin
      dec.op = ret_nop_pkg::OP_OTHER;
    end
  end
endmodule : op_decoder

/* File: test/core_return_nop_decode_tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module core_return_nop_decode_tb;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic clk_sys = 1'b0; // Core clock, 50 ns period
  logic srst = 1'b1; // Synchronous reset
  logic [13:0] insn = 14'h0000; // Instruction word
  logic insn_valid = 1'b0; // Instruction present
  logic [12:0] stack_top = 13'h0000; // Return stack top
  logic file_wr = 1'b0; // File write strobe
  logic [7:0] file_wdata = 8'h00; // File write data
  logic cfg_sel = 1'b0; // Config register selected
  logic file_w_wr = 1'b0; // Ordinary write of W
  logic [7:0] w_q; // Working register
  logic [7:0] cfg_q; // Config register
  logic [12:0] pc_q; // Program counter
  logic global_irq_enable_q; // Interrupt enable
  logic pop_q; // Stack pop pulse
  ret_nop_pkg::phase_t phase_q; // Phase
  logic second_cycle_q; // Idle second cycle
  logic fetch_q; // Fetch pulse
  int fails = 0; // Mismatch count
  int comparisons = 0; // Comparison count
  int pops; // Pops seen during one instruction
  int secs; // Idle-cycle phases seen
  logic gie_at [8]; // Interrupt enable per phase
  int fetches; // Fetch pulses seen
  // Clock
  always #25 clk_sys = ~clk_sys;
  core_return_nop_decode u_dut (
    .clk_sys(clk_sys), .srst(srst), .insn(insn), .insn_valid(insn_valid),
    .stack_top(stack_top), .file_wr(file_wr), .file_wdata(file_wdata), .cfg_sel(cfg_sel),
    .file_w_wr(file_w_wr), .w_q(w_q), .cfg_q(cfg_q), .pc_q(pc_q),
    .global_irq_enable_q(global_irq_enable_q), .pop_q(pop_q), .phase_q(phase_q),
    .second_cycle_q(second_cycle_q), .fetch_q(fetch_q)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  // Counts and verdict
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // Present one instruction, wait for its Q1 edge, then watch n cycles
  task automatic exec(input logic [13:0] code, input logic vld, input int n);
    int i;
    @(posedge clk_sys);
    insn <= code;
    insn_valid <= vld;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (!(phase_q === ret_nop_pkg::Q1 && second_cycle_q === 1'b0) && i < 20);
    if (i >= 20) begin
      fails++;
      test_done();
    end
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    pops = 0;
    secs = 0;
    fetches = 0;
    for (i = 0; i < n * 4; i++) begin
      @(negedge clk_sys);
      pops += (pop_q === 1'b1);
      secs += (second_cycle_q === 1'b1);
      fetches += (fetch_q === 1'b1);
      gie_at[i] = global_irq_enable_q;
    end
  endtask : exec
  // Ordinary instruction that writes W or a file register in Q4
  task automatic ordinary(input logic ww, input logic fw, input logic sel, input logic [7:0] d);
    @(posedge clk_sys);
    file_w_wr <= ww;
    file_wr <= fw;
    cfg_sel <= sel;
    file_wdata <= d;
    exec(14'h0880, 1'b1, 1);
    @(posedge clk_sys);
    file_w_wr <= 1'b0;
    file_wr <= 1'b0;
    cfg_sel <= 1'b0;
  endtask : ordinary
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    `CHK(w_q, ret_nop_pkg::W_RESET)
    `CHK(cfg_q, ret_nop_pkg::CFG_RESET)
    `CHK(pc_q, ret_nop_pkg::PC_RESET)
    `CHK(global_irq_enable_q, 1'b0)
    `CHK(pop_q, 1'b0)
    `CHK(phase_q, ret_nop_pkg::Q1)
    `CHK(second_cycle_q, 1'b0)
    `CHK(fetch_q, 1'b0)
  endtask : t_reset
  // Legacy load copies W, file path also reaches config
  task automatic t_cfg;
    ordinary(1'b1, 1'b0, 1'b0, 8'h5a);
    `CHK(w_q, 8'h5a)
    exec(ret_nop_pkg::CFG_LOAD_CODE, 1'b1, 1);
    `CHK(cfg_q, 8'h5a)
    `CHK(pops, 0)
    `CHK(secs, 0)
    ordinary(1'b0, 1'b1, 1'b1, 8'h3c);
    `CHK(cfg_q, 8'h3c)
    `CHK(w_q, 8'h5a)
  endtask : t_cfg
  // Two of the four idle encodings, both don't-care bits set in the second
  task automatic t_idle(input logic [13:0] code);
    exec(code, 1'b1, 1);
    `CHK(w_q, 8'h5a)
    `CHK(cfg_q, 8'h3c)
    `CHK(global_irq_enable_q, 1'b0)
    `CHK(pops, 0)
    `CHK(secs, 0)
    `CHK(fetches, 1)
  endtask : t_idle
  // Interrupt return: enable by Q3, pop in Q4, idle second cycle
  task automatic t_irq_ret;
    @(posedge clk_sys);
    stack_top <= 13'h1abc;
    exec(ret_nop_pkg::IRQ_RET_CODE, 1'b1, 2);
    `CHK(gie_at[0], 1'b0)
    `CHK(gie_at[2], 1'b1)
    `CHK(pops, 1)
    `CHK(secs, 4)
    `CHK(pc_q, 13'h1abc)
    `CHK(w_q, 8'h5a)
  endtask : t_irq_ret
  // Literal return: refused when not valid, then taken
  task automatic t_lit_ret;
    @(posedge clk_sys);
    stack_top <= 13'h0123;
    exec(14'h37a5, 1'b0, 2);
    `CHK(w_q, 8'h5a)
    `CHK(pops, 0)
    exec(14'h37a5, 1'b1, 2);
    `CHK(w_q, 8'ha5)
    `CHK(pc_q, 13'h0123)
    `CHK(pops, 1)
    `CHK(secs, 4)
    `CHK(cfg_q, 8'h3c)
  endtask : t_lit_ret
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    t_reset();
    t_cfg();
    t_idle(ret_nop_pkg::IDLE_CODE);
    t_idle(14'h0060);
    t_irq_ret();
    t_lit_ret();
    test_done();
  end
endmodule : core_return_nop_decode_tb
